// [cmc_pkg.sv]
// package for the cache mode control block: register map, fields, types
package cmc_pkg;

    // register byte offsets
    localparam logic [7:0] CMC_OFF_CTRL = 8'h00;
    localparam logic [7:0] CMC_OFF_MODE = 8'h04;
    localparam logic [7:0] CMC_OFF_INT_STAT = 8'h08;
    localparam logic [7:0] CMC_OFF_INT_CLR = 8'h0C;
    localparam logic [7:0] CMC_OFF_INT_EN = 8'h10;

    // primary control register fields
    localparam int CMC_BIT_INHIBIT = 30;
    localparam int CMC_BIT_WPOLICY = 29;
    localparam int CMC_BIT_RANGE_EN = 1;
    localparam int CMC_BIT_ALL_UC = 0;
    localparam logic [31:0] CMC_CTRL_MASK = 32'h6000_0003;
    // no-fill mode after reset, range-type registers enabled
    localparam logic [31:0] CMC_CTRL_RESET = 32'h4000_0002;

    // mode status fields
    localparam int CMC_BIT_NORMAL = 0;
    localparam int CMC_BIT_NOFILL = 1;
    localparam int CMC_BIT_STRICT = 2;

    // interrupt status bits
    localparam int CMC_INT_FAULT = 0;
    localparam int CMC_INT_MODE = 1;
    localparam int CMC_INT_W = 2;

    // error code carried by the protection fault
    localparam logic [15:0] CMC_FAULT_CODE = 16'h0000;

    typedef enum logic [1:0] {
        CMC_MODE_NORMAL = 2'b01,
        CMC_MODE_NOFILL = 2'b10
    } cmc_mode_type;

    typedef enum logic [1:0] {
        CMC_LINE_INVALID = 2'b00,
        CMC_LINE_SHARED = 2'b01,
        CMC_LINE_EXCL = 2'b10,
        CMC_LINE_MOD = 2'b11
    } cmc_line_type;

    // one cache access from the core, with its lookup result
    typedef struct packed {
        logic valid;
        logic write;
        logic hit;
        cmc_line_type line_state;
        logic cache_ok;
        logic upgrade_ok;
    } cmc_access_type;

    // handling chosen for that access
    typedef struct packed {
        logic valid;
        logic serve;
        logic mem_read;
        logic mem_write;
        logic fill;
        logic replace;
        logic update;
        logic state_we;
        cmc_line_type new_state;
        logic rd_inval;
    } cmc_decision_type;

endpackage

// [cmc_mode_ctrl.sv]
// cache operating mode control: flag decode, access handling, registers
`timescale 1ns/1ns

module cmc_mode_ctrl #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // cache access decisions
    input wire cmc_pkg::cmc_access_type acc_in,
    output cmc_pkg::cmc_decision_type dec_out,
    // snoop side
    input wire logic snoop_valid_in,
    output logic snoop_ack_out,
    output logic invalidate_allow_out,
    // mode and ordering
    output logic strict_order_out,
    // protection fault and interrupt
    output logic fault_out,
    output logic [15:0] fault_code_out,
    output logic irq_out
);
    import cmc_pkg::*;

    if (ADDR_W < 5) begin : g_addr_check
        $error("cmc_mode_ctrl: ADDR_W must be at least 5");
    end

    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        addr_is = (a == ADDR_W'(off));
    endfunction

    // ---------------- control register ----------------
    logic [31:0] ctrl_q, ctrl_d;
    logic fault_q, fault_d;
    logic ctrl_wr;
    logic bad_combo;
    logic mode_chg;

    assign ctrl_wr = reg_wr_in && addr_is(reg_addr_in, CMC_OFF_CTRL);
    assign bad_combo = !reg_wdata_in[CMC_BIT_INHIBIT] && reg_wdata_in[CMC_BIT_WPOLICY];

    always_comb begin
        ctrl_d = ctrl_q;
        fault_d = 1'b0;
        if (ctrl_wr && bad_combo) begin
            fault_d = 1'b1;
        end else if (ctrl_wr) begin
            ctrl_d = reg_wdata_in & CMC_CTRL_MASK;
        end
    end

    assign mode_chg = ctrl_wr && !bad_combo &&
        (reg_wdata_in[CMC_BIT_INHIBIT] != ctrl_q[CMC_BIT_INHIBIT]);

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl_q <= CMC_CTRL_RESET;
            fault_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            fault_q <= fault_d;
        end
    end

    assign fault_out = fault_q;
    assign fault_code_out = CMC_FAULT_CODE;

    // ---------------- mode decode ----------------
    cmc_mode_type mode;
    logic strict;

    // inhibit set means no-fill, write policy ignored
    assign mode = ctrl_q[CMC_BIT_INHIBIT] ? CMC_MODE_NOFILL : CMC_MODE_NORMAL;
    // ordering depends on range registers only
    assign strict = !ctrl_q[CMC_BIT_RANGE_EN] || ctrl_q[CMC_BIT_ALL_UC];

    // ---------------- access handling ----------------
    cmc_decision_type dec_q, dec_d;
    logic snoop_q, snoop_d;
    logic strict_q, strict_d;
    logic normal;

    assign normal = (mode == CMC_MODE_NORMAL);

    always_comb begin
        dec_d = '0;
        dec_d.new_state = CMC_LINE_INVALID;
        dec_d.valid = acc_in.valid;
        if (acc_in.valid) begin
            if (!acc_in.write) begin
                dec_d.serve = acc_in.hit;
                dec_d.mem_read = !acc_in.hit;
                dec_d.fill = !acc_in.hit && normal && acc_in.cache_ok;
                dec_d.replace = dec_d.fill;
                dec_d.state_we = dec_d.fill;
                dec_d.new_state = CMC_LINE_EXCL;
            end else if (acc_in.hit) begin
                dec_d.update = 1'b1;
                dec_d.state_we = 1'b1;
                dec_d.new_state = CMC_LINE_MOD;
                if (acc_in.line_state == CMC_LINE_SHARED) begin
                    dec_d.mem_write = 1'b1;
                    dec_d.new_state = CMC_LINE_SHARED;
                    if (acc_in.upgrade_ok) begin
                        dec_d.rd_inval = 1'b1;
                        dec_d.new_state = normal ? CMC_LINE_MOD : CMC_LINE_EXCL;
                    end
                end
            end else begin
                dec_d.mem_write = 1'b1;
                // fill on write miss in normal mode only
                dec_d.fill = normal && acc_in.cache_ok;
                dec_d.replace = dec_d.fill;
                dec_d.state_we = dec_d.fill;
                dec_d.new_state = CMC_LINE_MOD;
            end
        end
        snoop_d = snoop_valid_in;
        strict_d = strict;
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dec_q <= '0;
            snoop_q <= 1'b0;
            strict_q <= 1'b1;
        end else begin
            dec_q <= dec_d;
            snoop_q <= snoop_d;
            strict_q <= strict_d;
        end
    end

    assign dec_out = dec_q;
    assign snoop_ack_out = snoop_q;
    // invalidation allowed in both legal modes
    assign invalidate_allow_out = 1'b1;
    assign strict_order_out = strict_q;

    // ---------------- interrupts ----------------
    logic [CMC_INT_W-1:0] int_stat_q, int_stat_d;
    logic [CMC_INT_W-1:0] int_en_q, int_en_d;
    logic [CMC_INT_W-1:0] int_set;
    logic [CMC_INT_W-1:0] int_clr;
    logic irq_q, irq_d;

    always_comb begin
        int_set = '0;
        int_set[CMC_INT_FAULT] = ctrl_wr && bad_combo;
        int_set[CMC_INT_MODE] = mode_chg;
        int_clr = '0;
        if (reg_wr_in && addr_is(reg_addr_in, CMC_OFF_INT_CLR)) begin
            int_clr = reg_wdata_in[CMC_INT_W-1:0];
        end
        // set wins over a clear in the same cycle
        int_stat_d = (int_stat_q & ~int_clr) | int_set;
        int_en_d = int_en_q;
        if (reg_wr_in && addr_is(reg_addr_in, CMC_OFF_INT_EN)) begin
            int_en_d = reg_wdata_in[CMC_INT_W-1:0];
        end
        irq_d = |(int_stat_d & int_en_d);
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            int_stat_q <= '0;
            int_en_q <= '0;
            irq_q <= 1'b0;
        end else begin
            int_stat_q <= int_stat_d;
            int_en_q <= int_en_d;
            irq_q <= irq_d;
        end
    end

    assign irq_out = irq_q;

    // ---------------- register read ----------------
    logic [31:0] rdata_q, rdata_d;

    always_comb begin
        rdata_d = '0;
        if (reg_rd_in) begin
            if (addr_is(reg_addr_in, CMC_OFF_CTRL)) begin
                rdata_d = ctrl_q;
            end else if (addr_is(reg_addr_in, CMC_OFF_MODE)) begin
                rdata_d[CMC_BIT_NORMAL] = normal;
                rdata_d[CMC_BIT_NOFILL] = !normal;
                rdata_d[CMC_BIT_STRICT] = strict;
            end else if (addr_is(reg_addr_in, CMC_OFF_INT_STAT)) begin
                rdata_d[CMC_INT_W-1:0] = int_stat_q;
            end else if (addr_is(reg_addr_in, CMC_OFF_INT_EN)) begin
                rdata_d[CMC_INT_W-1:0] = int_en_q;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_out = rdata_q;

    // ---------------- assertions ----------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!reset_n_in);

    a_fault_on_bad: assert property (
        ctrl_wr && bad_combo |=> fault_out && $stable(ctrl_q) && fault_code_out == 16'h0000
    ) else $error("bad flag pair not faulted");

    a_no_bad_stored: assert property (
        !(!ctrl_q[CMC_BIT_INHIBIT] && ctrl_q[CMC_BIT_WPOLICY])
    ) else $error("illegal flag pair stored");

    a_new_mode_applied: assert property (
        ctrl_wr && !bad_combo ##1 acc_in.valid && !acc_in.write && !acc_in.hit
            && acc_in.cache_ok |=> dec_out.fill == !$past(ctrl_q[CMC_BIT_INHIBIT])
    ) else $error("new mode not applied to next access");

    a_nofill_no_alloc: assert property (
        acc_in.valid && ctrl_q[CMC_BIT_INHIBIT] |=> !dec_out.fill && !dec_out.replace
    ) else $error("no-fill mode allocated a line");

    a_write_miss_fill: assert property (
        acc_in.valid && acc_in.write && !acc_in.hit && acc_in.cache_ok
            && !ctrl_q[CMC_BIT_INHIBIT] |=> dec_out.fill && dec_out.mem_write
    ) else $error("normal write miss did not fill");

    a_nofill_write_miss: assert property (
        acc_in.valid && acc_in.write && !acc_in.hit && ctrl_q[CMC_BIT_INHIBIT]
            |=> dec_out.mem_write && !dec_out.fill
    ) else $error("no-fill write miss handled wrongly");

    a_read_hit_serve: assert property (
        acc_in.valid && !acc_in.write && acc_in.hit |=> dec_out.serve && !dec_out.mem_read
    ) else $error("read hit not served from cache");

    a_shared_upgrade: assert property (
        acc_in.valid && acc_in.write && acc_in.hit && acc_in.upgrade_ok
            && acc_in.line_state == CMC_LINE_SHARED
            |=> dec_out.rd_inval && dec_out.new_state ==
                ($past(ctrl_q[CMC_BIT_INHIBIT]) ? CMC_LINE_EXCL : CMC_LINE_MOD)
    ) else $error("shared write hit upgrade wrong");

    a_snoop_service: assert property (
        snoop_valid_in |=> snoop_ack_out && invalidate_allow_out
    ) else $error("snoop not serviced");

    a_strict_order: assert property (
        ctrl_wr && !bad_combo && reg_wdata_in[CMC_BIT_RANGE_EN]
            && !reg_wdata_in[CMC_BIT_ALL_UC] |=> ##1 !strict_order_out
    ) else $error("inhibit flag forced strict ordering");

    a_irq_level: assert property (
        irq_out == |(int_stat_q & int_en_q)
    ) else $error("interrupt output mismatch");

    a_fault_sticky: assert property (
        ctrl_wr && bad_combo |=> int_stat_q[CMC_INT_FAULT]
    ) else $error("fault status bit not set");

    c_bad_write: cover property (ctrl_wr && bad_combo);
    c_enter_normal: cover property (mode_chg && !reg_wdata_in[CMC_BIT_INHIBIT]);
    c_upgrade: cover property (dec_out.rd_inval);
    c_irq: cover property (irq_out);

endmodule

// [cmc_snoop_agent.sv]
// snooping bus agent model: issues snoop requests and counts the answers
`timescale 1ns/1ns
module cmc_snoop_agent (
    // clock
    input wire logic clk_sys_in,
    // snoop handshake
    input wire logic snoop_ack_in,
    output logic snoop_valid_out,
    // answers seen so far
    output int ack_count_out
);
    initial begin
        snoop_valid_out = 1'b0;
        ack_count_out = 0;
    end
    always @(posedge clk_sys_in) begin
        if (snoop_ack_in === 1'b1) begin
            ack_count_out <= ack_count_out + 1;
        end
    end
    // back-to-back snoops against held lines
    task automatic burst(input int n);
        repeat (n) begin
            @(posedge clk_sys_in);
            snoop_valid_out <= 1'b1;
        end
        @(posedge clk_sys_in);
        snoop_valid_out <= 1'b0;
    endtask
endmodule

// [testbench.sv]
// self-checking bench for the cache mode control block
`timescale 1ns/1ns
module testbench;
    import cmc_pkg::*;
    logic clk_sys_in;
    logic reset_n_in;
    logic [7:0] reg_addr_in;
    logic [31:0] reg_wdata_in;
    logic reg_wr_in;
    logic reg_rd_in;
    logic [31:0] reg_rdata_out;
    cmc_access_type acc_in;
    cmc_decision_type dec_out;
    logic snoop_valid_in;
    logic snoop_ack_out;
    logic invalidate_allow_out;
    logic strict_order_out;
    logic fault_out;
    logic [15:0] fault_code_out;
    logic irq_out;
    int ack_count;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    int acks0;

    cmc_mode_ctrl i_dut (
        .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .acc_in(acc_in), .dec_out(dec_out),
        .snoop_valid_in(snoop_valid_in), .snoop_ack_out(snoop_ack_out),
        .invalidate_allow_out(invalidate_allow_out),
        .strict_order_out(strict_order_out), .fault_out(fault_out),
        .fault_code_out(fault_code_out), .irq_out(irq_out)
    );
    cmc_snoop_agent i_agent (
        .clk_sys_in(clk_sys_in), .snoop_ack_in(snoop_ack_out),
        .snoop_valid_out(snoop_valid_in), .ack_count_out(ack_count)
    );

    initial begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1;
        chk(nm, e, reg_rdata_out);
    endtask

    // a = {write, hit, line_state, cache_ok, upgrade_ok}; only masked fields compared
    task automatic acc(input logic [5:0] a, input logic [10:0] e, input logic [10:0] m);
        @(posedge clk_sys_in);
        acc_in <= {1'b1, a};
        @(posedge clk_sys_in);
        acc_in <= '0;
        #1;
        chk("decision", {21'h00_0000, e}, {21'h00_0000, dec_out & m});
    endtask

    // control write with an access in the very next cycle: the access must see the new mode
    task automatic wr_acc(input logic [31:0] d, input logic [5:0] a, input logic [10:0] e,
            input logic [10:0] m);
        @(posedge clk_sys_in);
        reg_addr_in <= CMC_OFF_CTRL;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
        acc_in <= {1'b1, a};
        @(posedge clk_sys_in);
        acc_in <= '0;
        #1;
        chk("decision after write", {21'h00_0000, e}, {21'h00_0000, dec_out & m});
    endtask

    task automatic snoops(input int n);
        acks0 = ack_count;
        i_agent.burst(n);
        repeat (2) @(posedge clk_sys_in);
        #1;
        chk("snoop acks", n, ack_count - acks0);
        chk("inval allow", 1, {31'h0, invalidate_allow_out});
    endtask

    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            final_report();
        end
    end

    initial begin
        reset_n_in = 1'b0;
        reg_addr_in = 8'h00;
        reg_wdata_in = 32'h0000_0000;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        acc_in = '0;
        repeat (10) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        rd(CMC_OFF_CTRL, CMC_CTRL_RESET, "ctrl reset");
        rd(CMC_OFF_MODE, 32'h0000_0002, "mode reset");
        chk("strict", 0, {31'h0, strict_order_out});
        acc(6'h1A, 11'h600, 11'h760);
        acc(6'h02, 11'h500, 11'h760);
        acc(6'h22, 11'h480, 11'h4C0);
        acc(6'h37, 11'h49D, 11'h4DF);
        snoops(3);
        wr(CMC_OFF_INT_EN, 32'h0000_0001);
        // software keeps both flags clear for speed
        wr(CMC_OFF_CTRL, 32'h0000_0002);
        chk("irq masked", 0, {31'h0, irq_out});
        rd(CMC_OFF_INT_STAT, 32'h0000_0002, "stat mode");
        rd(CMC_OFF_MODE, 32'h0000_0001, "mode normal");
        acc(6'h02, 11'h56C, 11'h56E);
        acc(6'h00, 11'h500, 11'h560);
        acc(6'h22, 11'h4C6, 11'h4C6);
        acc(6'h37, 11'h49F, 11'h4DF);
        acc(6'h3A, 11'h41E, 11'h4DF);
        acc(6'h36, 11'h49A, 11'h4DF);
        snoops(2);
        wr(CMC_OFF_CTRL, 32'h2000_0002);
        chk("fault", 1, {31'h0, fault_out});
        chk("fault code", 0, {16'h0000, fault_code_out});
        chk("irq fault", 1, {31'h0, irq_out});
        rd(CMC_OFF_CTRL, 32'h0000_0002, "ctrl kept");
        rd(CMC_OFF_INT_STAT, 32'h0000_0003, "stat fault");
        wr(CMC_OFF_INT_CLR, 32'h0000_0003);
        chk("irq cleared", 0, {31'h0, irq_out});
        rd(CMC_OFF_INT_STAT, 32'h0000_0000, "stat clear");
        rd(CMC_OFF_INT_EN, 32'h0000_0001, "int en");
        wr(CMC_OFF_CTRL, 32'h6000_0002);
        rd(CMC_OFF_CTRL, 32'h6000_0002, "ctrl both");
        rd(CMC_OFF_MODE, 32'h0000_0002, "mode both");
        acc(6'h02, 11'h500, 11'h760);
        wr(CMC_OFF_CTRL, 32'h4000_0000);
        rd(CMC_OFF_MODE, 32'h0000_0006, "mode strict");
        chk("strict", 1, {31'h0, strict_order_out});
        acc(6'h22, 11'h480, 11'h4C0);
        snoops(2);
        wr_acc(32'h0000_0003, 6'h02, 11'h56C, 11'h56E);
        rd(CMC_OFF_MODE, 32'h0000_0005, "mode all uncached");
        chk("strict uc", 1, {31'h0, strict_order_out});
        rd(8'h20, 32'h0000_0000, "unmapped");
        final_report();
    end
endmodule
